// ===== cpg_line_path.sv
/*
 * One LVDS output line data path: inversion and power-down of the line.
 * Assumes sample and test-pattern data arrive on mclk.
 */
`timescale 1ns/1ps
module cpg_line_path
    import cpg_pkg::*;
#(
    parameter int DW = CPG_DATA_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic flip,
    input wire logic sleep,
    input wire logic pattern_on,
    input wire logic [DW-1:0] sample,
    input wire logic [DW-1:0] pattern,
    output logic [DW-1:0] line_out
);
    wire [DW-1:0] data_sel;
    wire [DW-1:0] next_line;

    assign data_sel = pattern_on ? pattern : (flip ? ~sample : sample);
    assign next_line = sleep ? '0 : data_sel;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            line_out <= '0;
        end else if (ce) begin
            line_out <= next_line;
        end
    end
endmodule : cpg_line_path

// ===== cpg_pkg.sv
/*
 * Constants for the channel power, inversion, gain and offset register slice.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package cpg_pkg;
    localparam int CPG_DATA_W = 14;
    localparam int CPG_NUM_LINES = 4;
    // Register indices; byte address is four times the index
    localparam logic [7:0] CPG_IDX_POWER = 8'h18;
    localparam logic [7:0] CPG_IDX_CH5_GAIN = 8'h19;
    localparam logic [7:0] CPG_IDX_CH5_MIRROR = 8'h1a;
    localparam logic [7:0] CPG_IDX_APPLY = 8'h40;
    localparam logic [7:0] CPG_IDX_STATUS = 8'h41;
    localparam logic [15:0] CPG_POWER_RESET = 16'h0000;
    localparam logic [15:0] CPG_CH5_RESET = 16'h0000;
    localparam int CPG_DIG_LO = 12;
    localparam int CPG_LINE_LO = 8;
    localparam int CPG_ANA_LO = 4;
    localparam int CPG_FLIP_LO = 0;
    localparam int CPG_GAIN_HI = 15;
    localparam int CPG_GAIN_LO = 11;
    localparam int CPG_OFS_HI = 9;
    localparam int CPG_OFS_LO = 0;
    localparam int CPG_GAIN_BIT = 0;
    localparam int CPG_OFS_BIT = 1;
    localparam logic [31:0] CPG_UNMAPPED = 32'h00000000;
endpackage : cpg_pkg

// ===== cpg_regs.sv
/*
 * Channel power, output inversion, channel 5 gain and offset register slice.
 * Assumes a classic Wishbone master on mclk and same-domain data inputs.
 */
// Our own choice: the Wishbone slave port.
// Notes on behaviour
// - Bits 15:12 sleep digital blocks 4..1
// - Bits 11:8 sleep output lines 4..1
// - Bits 7:4 sleep analog blocks 4..1
// - Bits 3:0 invert output line data
// - Inversion never alters test pattern data
// - Channel 5 gain is N times 0.2 dB
// - Channel 5 offset, 10-bit two's complement
`timescale 1ns/1ps
module cpg_regs
    import cpg_pkg::*;
#(
    parameter int DW = CPG_DATA_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [CPG_NUM_LINES-1:0] pattern_on,
    input wire logic [CPG_NUM_LINES*DW-1:0] sample_in,
    input wire logic [CPG_NUM_LINES*DW-1:0] pattern_in,
    output logic [CPG_NUM_LINES*DW-1:0] line_out,
    output logic [3:0] digital_block_sleep,
    output logic [3:0] output_line_sleep,
    output logic [3:0] analog_block_sleep,
    output logic global_gain_apply,
    output logic global_offset_apply,
    output logic [4:0] fifth_channel_gain_step,
    output logic [9:0] fifth_channel_offset_value
);
    logic [15:0] power_reg;
    logic [15:0] ch5_reg;
    logic [15:0] mirror_reg;
    logic [1:0] apply_reg;

    // Byte-lane merge; lanes 2 and 3 carry no register bits
    function automatic logic [15:0] cpg_merge(input logic [15:0] old,
                                              input logic [31:0] din,
                                              input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = din[7:0];
        if (sel[1]) r[15:8] = din[15:8];
        return r;
    endfunction : cpg_merge

    // Aligned word inside the register window at this index
    function automatic logic cpg_hit(input logic [31:0] adr,
                                     input logic [7:0] index);
        logic ok;
        ok = (adr[1:0] == 2'b00) && (adr[31:10] == 22'h000000);
        return ok && (adr[9:2] == index);
    endfunction : cpg_hit

    // Read-back word; unmapped words read as zero
    function automatic logic [31:0] cpg_read(input logic [31:0] adr,
                                             input logic [15:0] pow,
                                             input logic [15:0] ch5,
                                             input logic [15:0] mir,
                                             input logic [1:0] app,
                                             input logic bad);
        logic [31:0] r;
        r = CPG_UNMAPPED;
        if (cpg_hit(adr, CPG_IDX_POWER)) r = {16'h0000, pow};
        if (cpg_hit(adr, CPG_IDX_CH5_GAIN)) r = {16'h0000, ch5};
        if (cpg_hit(adr, CPG_IDX_CH5_MIRROR)) r = {16'h0000, mir};
        if (cpg_hit(adr, CPG_IDX_APPLY)) r = {30'h0, app};
        if (cpg_hit(adr, CPG_IDX_STATUS)) r = {31'h0, bad};
        return r;
    endfunction : cpg_read

    // Request taken while no ack is out
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A write lands on the edge at which the master samples ack
    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire hit_pow = cpg_hit(wb_adr_i, CPG_IDX_POWER);
    wire hit_ch5 = cpg_hit(wb_adr_i, CPG_IDX_CH5_GAIN);
    wire hit_mir = cpg_hit(wb_adr_i, CPG_IDX_CH5_MIRROR);
    wire hit_app = cpg_hit(wb_adr_i, CPG_IDX_APPLY);
    wire wr_pow = wr && hit_pow;
    wire wr_ch5 = wr && hit_ch5;
    wire wr_mir = wr && hit_mir;
    wire wr_app = wr && hit_app && wb_sel_i[0];
    // Host keeps both offset copies equal; any difference is flagged
    wire mismatch = ch5_reg[CPG_OFS_HI:CPG_OFS_LO]
        != mirror_reg[CPG_OFS_HI:CPG_OFS_LO];
    wire [31:0] rd_mux = cpg_read(wb_adr_i, power_reg, ch5_reg, mirror_reg,
        apply_reg, mismatch);
    wire [15:0] next_power = cpg_merge(power_reg, wb_dat_i, wb_sel_i);
    wire [15:0] next_ch5 = cpg_merge(ch5_reg, wb_dat_i, wb_sel_i);
    wire [15:0] next_mirror = cpg_merge(mirror_reg, wb_dat_i, wb_sel_i);
    wire [1:0] next_apply = wb_dat_i[1:0];

    // Control values taken from the bank
    wire [3:0] next_dig_sleep = power_reg[CPG_DIG_LO+:4];
    wire [3:0] next_line_sleep = power_reg[CPG_LINE_LO+:4];
    wire [3:0] next_ana_sleep = power_reg[CPG_ANA_LO+:4];
    wire [3:0] line_flip = power_reg[CPG_FLIP_LO+:4];
    wire [4:0] gain_field = ch5_reg[CPG_GAIN_HI:CPG_GAIN_LO];
    wire [9:0] offset_field = ch5_reg[CPG_OFS_HI:CPG_OFS_LO];
    // Gain and offset held at zero unless globally applied
    wire [4:0] next_gain_step =
        apply_reg[CPG_GAIN_BIT] ? gain_field : 5'h00;
    wire [9:0] next_offset_value =
        apply_reg[CPG_OFS_BIT] ? offset_field : 10'h000;

    // Ack one cycle after the request is taken
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= req;
        end
    end

    // Read data stands with ack only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_dat_o <= req ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_reg <= CPG_POWER_RESET;
        end else if (ce && wr_pow) begin
            power_reg <= next_power;
        end
    end

    // Unused bits stored as written
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch5_reg <= CPG_CH5_RESET;
        end else if (ce && wr_ch5) begin
            ch5_reg <= next_ch5;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mirror_reg <= CPG_CH5_RESET;
        end else if (ce && wr_mir) begin
            mirror_reg <= next_mirror;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            apply_reg <= 2'b00;
        end else if (ce && wr_app) begin
            apply_reg <= next_apply;
        end
    end

    // Sleep controls follow the bank one edge later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            digital_block_sleep <= 4'h0;
            output_line_sleep <= 4'h0;
            analog_block_sleep <= 4'h0;
        end else if (ce) begin
            digital_block_sleep <= next_dig_sleep;
            output_line_sleep <= next_line_sleep;
            analog_block_sleep <= next_ana_sleep;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            global_gain_apply <= 1'b0;
            global_offset_apply <= 1'b0;
        end else if (ce) begin
            global_gain_apply <= apply_reg[CPG_GAIN_BIT];
            global_offset_apply <= apply_reg[CPG_OFS_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fifth_channel_gain_step <= 5'h00;
        end else if (ce) begin
            fifth_channel_gain_step <= next_gain_step;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fifth_channel_offset_value <= 10'h000;
        end else if (ce) begin
            fifth_channel_offset_value <= next_offset_value;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CPG_NUM_LINES; g++) begin : g_line
            cpg_line_path #(.DW(DW)) u_line (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .flip(line_flip[g]),
                .sleep(power_reg[CPG_LINE_LO+g]),
                .pattern_on(pattern_on[g]),
                .sample(sample_in[g*DW+:DW]),
                .pattern(pattern_in[g*DW+:DW]),
                .line_out(line_out[g*DW+:DW])
            );
        end
    endgenerate
endmodule : cpg_regs

// ===== cpg_regs_sva.sv
/* Port assertions for cpg_regs. Assumes the bind below places it. */
`timescale 1ns/1ps
module cpg_regs_sva
    import cpg_pkg::*;
#(
    parameter int DW = CPG_DATA_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [CPG_NUM_LINES-1:0] pattern_on,
    input wire logic [CPG_NUM_LINES*DW-1:0] pattern_in,
    input wire logic [CPG_NUM_LINES*DW-1:0] line_out,
    input wire logic [3:0] output_line_sleep,
    input wire logic global_gain_apply,
    input wire logic global_offset_apply,
    input wire logic [4:0] fifth_channel_gain_step,
    input wire logic [9:0] fifth_channel_offset_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_ack_one_cycle: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_has_req: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_sleep_line_zero: assert property (
        output_line_sleep[0] |-> line_out[DW-1:0] == '0)
        else $error("sleeping line not zero");
    a_pattern_passes: assert property (
        !output_line_sleep[0] && $past(ce && !rst && pattern_on[0])
        |-> line_out[DW-1:0] == $past(pattern_in[DW-1:0]))
        else $error("pattern altered");
    a_gain_gated: assert property (
        !global_gain_apply |-> fifth_channel_gain_step == 5'h00)
        else $error("gain out while not applied");
    a_offset_gated: assert property (
        !global_offset_apply |-> fifth_channel_offset_value == 10'h000)
        else $error("offset out while not applied");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    a_idle_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data without ack");
    c_apply_ack: cover property (wb_ack_o && global_gain_apply);
    c_pattern: cover property (pattern_on[0] && !output_line_sleep[0]);
    c_sleep: cover property (output_line_sleep[0]);
endmodule : cpg_regs_sva
bind cpg_regs cpg_regs_sva #(.DW(DW)) u_sva (.mclk(mclk), .rst(rst),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pattern_on(pattern_on), .pattern_in(pattern_in),
    .line_out(line_out), .output_line_sleep(output_line_sleep),
    .global_gain_apply(global_gain_apply),
    .global_offset_apply(global_offset_apply),
    .fifth_channel_gain_step(fifth_channel_gain_step),
    .fifth_channel_offset_value(fifth_channel_offset_value));

// ===== tb.sv
/* Bench for cpg_regs. Assumes one clock and byte addresses index*4. */
`timescale 1ns/1ps
module tb
    import cpg_pkg::*;
;
    logic mclk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack, ga, oa;
    logic [31:0] adr = 0, wdat = 0, rdat, q, d;
    logic [3:0] pon = 0, sel = 4'hf, ds, ls, asl;
    logic [55:0] smp = 0, pat = 0, lo, lsv;
    logic [4:0] gs;
    logic [9:0] ov;
    integer num_errors = 0, n_tests = 0, seed = 32'h7a79ff13, i, n, p, ap;
    int mdl [int];
    cpg_regs uut (.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pattern_on(pon),
        .sample_in(smp), .pattern_in(pat), .line_out(lo),
        .digital_block_sleep(ds), .output_line_sleep(ls),
        .analog_block_sleep(asl), .global_gain_apply(ga),
        .global_offset_apply(oa), .fifth_channel_gain_step(gs),
        .fifth_channel_offset_value(ov));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(logic w, logic [31:0] a, logic [31:0] dv);
        int k;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, dv};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (k == 50) begin
            num_errors++;
            stop_test();
        end
        if (!w) chk("read", mdl.exists(a) ? mdl[a] : 0, q);
        else if (mdl.exists(a))
            mdl[a] = {sel[1] ? dv[15:8] : 8'(mdl[a] >> 8),
                sel[0] ? dv[7:0] : 8'(mdl[a])};
        @(posedge mclk);
    endtask : acc
    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    initial forever #12.5 mclk = ~mclk;
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        mdl[32'h60] = 0;
        mdl[32'h64] = 0;
        mdl[32'h68] = 0;
        mdl[32'h100] = 0;
        mdl[32'h104] = 0;
        repeat (5) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        for (i = 0; i < 3; i++) acc(0, 32'h60 + 4 * i, 0);
        for (n = 0; n < 12; n++) begin
            d = $random(seed);
            ap = $random(seed) & 3;
            sel <= 4'(n % 4) | 4'hc;
            acc(1, 32'h60, d);
            sel <= 4'hf;
            acc(1, 32'h64, d[31:16] & 32'hfbff);
            acc(1, 32'h68, d[25:16]);
            acc(1, 32'h100, ap);
            acc(1, 32'h1fc, d);
            for (i = 0; i < 3; i++) acc(0, 32'h60 + 4 * i, 0);
            acc(0, 32'h100, 0);
            mdl[32'h104] = ((mdl[32'h64] ^ mdl[32'h68]) & 32'h3ff) != 0;
            acc(0, 32'h104, 0);
            acc(0, 32'h1fc, 0);
            smp <= 56'({$random(seed), $random(seed)});
            pat <= 56'({$random(seed), $random(seed)});
            pon <= 4'($random(seed));
            repeat (2) @(posedge mclk);
            #1;
            p = mdl[32'h60];
            chk("dig", p[15:12], ds);
            chk("line", p[11:8], ls);
            chk("ana", p[7:4], asl);
            for (i = 0; i < 4; i++)
                chk("data", p[8 + i] ? 14'h0 : pon[i] ? pat[14 * i +: 14] :
                    p[i] ? 14'(~smp[14 * i +: 14]) : smp[14 * i +: 14],
                    lo[14 * i +: 14]);
            p = mdl[32'h64];
            chk("gain", ap[0] ? p[15:11] : 0, gs);
            chk("ofs", ap[1] ? p[9:0] : 0, ov);
            chk("gapp", ap[0], ga);
            chk("oapp", ap[1], oa);
            @(posedge mclk);
            lsv = lo;
            ce <= 1'b0;
            smp <= ~smp;
            pat <= ~pat;
            repeat (3) @(posedge mclk);
            #1;
            chk("hold", lsv[31:0], lo[31:0]);
            chk("hold", {8'h00, lsv[55:32]}, {8'h00, lo[55:32]});
            @(posedge mclk);
            ce <= 1'b1;
            $display("test %0d done", n);
        end
        stop_test();
    end
endmodule : tb
